// ===== design/sgsel_pkg.sv
package sgsel_pkg;

   // ==========================================================
   // bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DELAY = 8'h04;
   localparam logic [7:0] OFS_REQUEST = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;

   // ==========================================================
   // control register fields
   localparam int CTRL_COUNT_LSB = 0;
   localparam int CTRL_COUNT_MSB = 1;
   localparam int CTRL_ASSIGN_ONE_BIT = 2;
   localparam int CTRL_ASSIGN_TWO_BIT = 3;
   localparam int CTRL_INVERT_BIT = 4;

   // ==========================================================
   // status register fields
   localparam int STAT_GROUP_LSB = 0;
   localparam int STAT_GROUP_MSB = 1;
   localparam int STAT_PENDING_BIT = 2;
   localparam int STAT_LEVEL_BIT = 3;
   localparam int STAT_MISMATCH_BIT = 4;

   // ==========================================================
   // group codes, shared by count select, request and status
   localparam logic [1:0] GRP_CODE_ONE = 2'h1;
   localparam logic [1:0] GRP_CODE_TWO = 2'h2;

   // ==========================================================
   // values after reset
   localparam logic [1:0] RST_GROUP_COUNT = 2'h2;
   localparam logic RST_ASSIGN_ONE = 1'b1;
   localparam logic RST_ASSIGN_TWO = 1'b1;
   localparam logic RST_INVERT = 1'b0;
   localparam logic [15:0] RST_DELAY_MS = 16'h0064;
   localparam logic [1:0] RST_REQUEST = 2'h1;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int DELAY_TICK_NS = 1000000;
   localparam int DELAY_TICK_CYCLES = DELAY_TICK_NS / CLK_PERIOD_NS;
   localparam int TICK_W = 15;
   localparam logic [1:0] INIT_CYCLES = 2'h2;

   // ==========================================================
   // selector states
   typedef enum logic [0:0] {
      SGS_INIT,
      SGS_RUN
   } sgsel_state_t;

endpackage

// ===== design/sgsel_top.sv
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// Summary of operation
// R1: two setting groups exist; exactly one is active at all times.
// R2: group count code 1 means single group, code 2 means two groups.
// R3: single-group operation forces group one whatever input or request says.
// R4: every group change is accepted and pulses a reset of protection timers and flags; entering group two at power-up gives no pulse.
// R5: select input works on level: low asks group one, high group two.
// R6: input-driven switch from group one to two waits the up-switch delay.
// R7: input-driven return from group two to one is immediate.
// R8: after power-up the first active group follows the select input.
// R9: input asking group two at power-up enters group two without delay.
// R10: inversion set makes an energized input pick group one.
// R11: configurer assigns the input in both banks; on mismatch no switch happens.
// R12: panel and remote share one request value; writes of code 1 or 2 overwrite it.
// R13: an assigned select input has priority; panel and remote requests do nothing.
// R14: with no input assigned, active group equals the shared request value.
// R15: requests blocked by priority are dropped, never kept for later.
// R16: active group is readable as status and drives indicator outputs.
// R17: withdrawing the input before the delay expires cancels the pending switch.
// R18: the up-switch delay is counted from the core clock, loaded from its setting.
module sgsel_top #(
   parameter int TICK_CYCLES = sgsel_pkg::DELAY_TICK_CYCLES
) (
   input wire logic CORE_CLK_IN,
   input wire logic RESETN_IN,
   input wire logic HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic HREADY_IN,
   output logic [31:0] HRDATA_OUT,
   output logic HREADYOUT_OUT,
   output logic HRESP_OUT,
   input wire logic GROUP_SEL_IN,
   output logic GROUP_ONE_ACTIVE_OUT,
   output logic GROUP_TWO_ACTIVE_OUT,
   output logic GROUP_CHANGE_RESET_OUT,
   output logic SWITCH_PENDING_OUT
);

   // ==========================================================
   // state record
   typedef struct packed {
      sgsel_pkg::sgsel_state_t fsm;
      logic [1:0] init_cnt;
      logic sel_meta;
      logic sel_sync;
      logic ap_valid;
      logic ap_write;
      logic [7:0] ap_addr;
      logic [31:0] rdata;
      logic [1:0] group_count;
      logic assign_one;
      logic assign_two;
      logic invert;
      logic [15:0] delay_ms;
      logic [1:0] request;
      logic group_two;
      logic pending;
      logic [15:0] ms_left;
      logic [14:0] tick_cnt;
      logic change_pulse;
      logic ready;
      logic resp;
      logic group_one;
   } sgsel_regs_t;

   localparam logic [14:0] TICK_LAST = 15'(TICK_CYCLES - 1);

   sgsel_regs_t state_reg;
   sgsel_regs_t state_next;

   // ==========================================================
   // next-state logic
   always_comb begin
      sgsel_regs_t s;
      logic two_groups;
      logic input_cfg;
      logic input_ok;
      logic level_two;
      logic want_two;
      logic blocked;
      logic [31:0] rd;
      logic [1:0] wr_count;
      logic wr_assign_one;
      logic wr_assign_two;
      logic wr_invert;
      logic [15:0] wr_delay;
      logic [1:0] wr_request;
      logic mismatch;
      logic [31:0] ctrl_img;
      logic [31:0] delay_img;
      logic [31:0] request_img;
      logic [31:0] status_img;
      s = state_reg;
      two_groups = 1'b0;
      input_cfg = 1'b0;
      input_ok = 1'b0;
      level_two = 1'b0;
      want_two = 1'b0;
      blocked = 1'b0;
      rd = 32'h0000_0000;
      wr_count = 2'h0;
      wr_assign_one = 1'b0;
      wr_assign_two = 1'b0;
      wr_invert = 1'b0;
      wr_delay = 16'h0000;
      wr_request = 2'h0;
      mismatch = 1'b0;
      ctrl_img = 32'h0000_0000;
      delay_img = 32'h0000_0000;
      request_img = 32'h0000_0000;
      status_img = 32'h0000_0000;

      // two-flop synchroniser; first stage feeds only the second
      s.sel_meta = GROUP_SEL_IN;
      s.sel_sync = state_reg.sel_meta;

      // configuration decode from the current register values
      two_groups = (state_reg.group_count == sgsel_pkg::GRP_CODE_TWO); // see R2
      input_cfg = state_reg.assign_one | state_reg.assign_two;
      input_ok = state_reg.assign_one & state_reg.assign_two; // see R11
      level_two = state_reg.sel_sync ^ state_reg.invert; // see R5 // see R10
      blocked = two_groups & input_cfg; // see R13
      mismatch = input_cfg & ~input_ok; // see R11

      // ==========================================================
      // write data fields
      // split once so the decode below reads short names, not slices
      wr_count = HWDATA_IN[sgsel_pkg::CTRL_COUNT_MSB:sgsel_pkg::CTRL_COUNT_LSB];
      wr_assign_one = HWDATA_IN[sgsel_pkg::CTRL_ASSIGN_ONE_BIT];
      wr_assign_two = HWDATA_IN[sgsel_pkg::CTRL_ASSIGN_TWO_BIT];
      wr_invert = HWDATA_IN[sgsel_pkg::CTRL_INVERT_BIT];
      wr_delay = HWDATA_IN[15:0];
      wr_request = HWDATA_IN[1:0];

      // ==========================================================
      // data phase: register writes
      if (state_reg.ap_valid && state_reg.ap_write) begin
         case (state_reg.ap_addr)
            sgsel_pkg::OFS_CTRL: begin
               // unknown count codes are dropped so the mode stays defined
               if (wr_count == sgsel_pkg::GRP_CODE_ONE ||
                   wr_count == sgsel_pkg::GRP_CODE_TWO) begin
                  s.group_count = wr_count; // see R2
               end
               s.assign_one = wr_assign_one;
               s.assign_two = wr_assign_two;
               s.invert = wr_invert;
            end
            sgsel_pkg::OFS_DELAY: begin
               s.delay_ms = wr_delay;
            end
            sgsel_pkg::OFS_REQUEST: begin
               // blocked requests vanish here; nothing is queued
               if (!blocked) begin // see R15
                  if (wr_request == sgsel_pkg::GRP_CODE_ONE ||
                      wr_request == sgsel_pkg::GRP_CODE_TWO) begin
                     s.request = wr_request; // see R12
                  end
               end
            end
            sgsel_pkg::OFS_STATUS: begin
               // status is read-only; a write leaves every field alone
               s.request = s.request;
            end
            default: begin
               s.request = s.request;
            end
         endcase
      end

      // ==========================================================
      // group selection
      s.change_pulse = 1'b0;
      case (state_reg.fsm)
         sgsel_pkg::SGS_INIT: begin
            // wait for the synchroniser to hold the real pin level
            s.init_cnt = state_reg.init_cnt + 2'h1;
            s.pending = 1'b0;
            s.ms_left = 16'h0000;
            s.tick_cnt = 15'h0000;
            if (state_reg.init_cnt == sgsel_pkg::INIT_CYCLES) begin
               s.fsm = sgsel_pkg::SGS_RUN;
               if (!two_groups) begin
                  s.group_two = 1'b0; // see R3
               end else if (input_cfg) begin
                  // power-up takes the input level with no delay
                  s.group_two = input_ok & level_two; // see R8 // see R9
               end else begin
                  s.group_two = (state_reg.request == sgsel_pkg::GRP_CODE_TWO); // see R14
               end
            end
         end
         sgsel_pkg::SGS_RUN: begin
            want_two = state_reg.group_two;
            if (!two_groups) begin
               want_two = 1'b0; // see R3
               s.pending = 1'b0;
               s.ms_left = 16'h0000;
               s.tick_cnt = 15'h0000;
            end else if (input_cfg) begin
               if (!input_ok) begin
                  // inconsistent assignment: keep the present group
                  want_two = state_reg.group_two; // see R11
                  s.pending = 1'b0;
                  s.ms_left = 16'h0000;
                  s.tick_cnt = 15'h0000;
               end else if (!level_two) begin
                  want_two = 1'b0; // see R7
                  s.pending = 1'b0; // see R17
                  s.ms_left = 16'h0000;
                  s.tick_cnt = 15'h0000;
               end else if (!state_reg.group_two) begin
                  if (!state_reg.pending) begin
                     s.pending = 1'b1; // see R6
                     s.ms_left = state_reg.delay_ms; // see R18
                     s.tick_cnt = 15'h0000;
                  end else if (state_reg.ms_left == 16'h0000) begin
                     want_two = 1'b1; // see R6
                     s.pending = 1'b0;
                  end else if (state_reg.tick_cnt == TICK_LAST) begin
                     s.tick_cnt = 15'h0000;
                     s.ms_left = state_reg.ms_left - 16'h0001; // see R18
                  end else begin
                     s.tick_cnt = state_reg.tick_cnt + 15'h0001;
                  end
               end else begin
                  want_two = 1'b1; // see R5
                  s.pending = 1'b0;
               end
            end else begin
               want_two = (state_reg.request == sgsel_pkg::GRP_CODE_TWO); // see R14
               s.pending = 1'b0;
               s.ms_left = 16'h0000;
               s.tick_cnt = 15'h0000;
            end
            // one bit holds the group, so exactly one is always active
            s.group_two = want_two; // see R1
            s.change_pulse = (want_two != state_reg.group_two); // see R4
         end
         default: begin
            s.fsm = sgsel_pkg::SGS_INIT;
            s.init_cnt = 2'h0;
         end
      endcase

      // ==========================================================
      // address phase: capture and read data
      s.ap_valid = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
      s.ap_write = HWRITE_IN;
      s.ap_addr = HADDR_IN[7:0];
      // images come from the updated copy so a write just before is seen
      ctrl_img[sgsel_pkg::CTRL_COUNT_MSB:sgsel_pkg::CTRL_COUNT_LSB] = s.group_count;
      ctrl_img[sgsel_pkg::CTRL_ASSIGN_ONE_BIT] = s.assign_one;
      ctrl_img[sgsel_pkg::CTRL_ASSIGN_TWO_BIT] = s.assign_two;
      ctrl_img[sgsel_pkg::CTRL_INVERT_BIT] = s.invert;
      delay_img[15:0] = s.delay_ms;
      request_img[1:0] = s.request;
      status_img[sgsel_pkg::STAT_GROUP_MSB:sgsel_pkg::STAT_GROUP_LSB] =
         s.group_two ? sgsel_pkg::GRP_CODE_TWO : sgsel_pkg::GRP_CODE_ONE; // see R16
      status_img[sgsel_pkg::STAT_PENDING_BIT] = s.pending;
      status_img[sgsel_pkg::STAT_LEVEL_BIT] = s.sel_sync;
      status_img[sgsel_pkg::STAT_MISMATCH_BIT] = mismatch;

      // read mux, one image per offset
      case (HADDR_IN[7:0])
         sgsel_pkg::OFS_CTRL: begin
            rd = ctrl_img;
         end
         sgsel_pkg::OFS_DELAY: begin
            rd = delay_img;
         end
         sgsel_pkg::OFS_REQUEST: begin
            rd = request_img;
         end
         sgsel_pkg::OFS_STATUS: begin
            rd = status_img;
         end
         default: begin
            rd = 32'h0000_0000;
         end
      endcase
      if (s.ap_valid && !HWRITE_IN) begin
         s.rdata = rd;
      end

      // ==========================================================
      // registered pin copies
      // even constant answers leave a flop, so no pin is driven by logic
      s.ready = 1'b1;
      s.resp = 1'b0;
      s.group_one = ~s.group_two; // see R1

      state_next = s;
   end

   // ==========================================================
   // state register
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RESETN_IN) begin
         state_reg.fsm <= sgsel_pkg::SGS_INIT;
         state_reg.init_cnt <= 2'h0;
         state_reg.sel_meta <= 1'b0;
         state_reg.sel_sync <= 1'b0;
         state_reg.ap_valid <= 1'b0;
         state_reg.ap_write <= 1'b0;
         state_reg.ap_addr <= 8'h00;
         state_reg.rdata <= 32'h0000_0000;
         state_reg.group_count <= sgsel_pkg::RST_GROUP_COUNT;
         state_reg.assign_one <= sgsel_pkg::RST_ASSIGN_ONE;
         state_reg.assign_two <= sgsel_pkg::RST_ASSIGN_TWO;
         state_reg.invert <= sgsel_pkg::RST_INVERT;
         state_reg.delay_ms <= sgsel_pkg::RST_DELAY_MS;
         state_reg.request <= sgsel_pkg::RST_REQUEST;
         state_reg.group_two <= 1'b0;
         state_reg.pending <= 1'b0;
         state_reg.ms_left <= 16'h0000;
         state_reg.tick_cnt <= 15'h0000;
         state_reg.change_pulse <= 1'b0;
         state_reg.ready <= 1'b1;
         state_reg.resp <= 1'b0;
         state_reg.group_one <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // outputs, all straight from the state register
   assign HRDATA_OUT = state_reg.rdata;
   // zero-wait slave: ready and okay are held in flops
   assign HREADYOUT_OUT = state_reg.ready;
   assign HRESP_OUT = state_reg.resp;
   assign GROUP_ONE_ACTIVE_OUT = state_reg.group_one; // see R16
   assign GROUP_TWO_ACTIVE_OUT = state_reg.group_two; // see R16
   assign GROUP_CHANGE_RESET_OUT = state_reg.change_pulse; // see R4
   assign SWITCH_PENDING_OUT = state_reg.pending;

endmodule

// ===== testbench/sgsel_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// port-level checks of the group selector
module sgsel_assertions (
   input wire logic CORE_CLK_IN,
   input wire logic RESETN_IN,
   input wire logic HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic HREADY_IN,
   input wire logic [31:0] HRDATA_OUT,
   input wire logic HREADYOUT_OUT,
   input wire logic HRESP_OUT,
   input wire logic GROUP_ONE_ACTIVE_OUT,
   input wire logic GROUP_TWO_ACTIVE_OUT,
   input wire logic GROUP_CHANGE_RESET_OUT,
   input wire logic SWITCH_PENDING_OUT
);
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   sequence rd_taken_s(logic [7:0] a);
      HSEL_IN && HTRANS_IN[1] && HREADY_IN && !HWRITE_IN && HADDR_IN[7:0] == a;
   endsequence
   one_group_a: assert property (GROUP_ONE_ACTIVE_OUT != GROUP_TWO_ACTIVE_OUT)
      else $error("group outputs not exclusive");
   bus_okay_a: assert property (HREADYOUT_OUT && !HRESP_OUT)
      else $error("bus answer not ready and okay");
   pulse_cause_a: assert property (GROUP_CHANGE_RESET_OUT |-> $changed(GROUP_TWO_ACTIVE_OUT))
      else $error("change pulse without group change");
   pulse_width_a: assert property (GROUP_CHANGE_RESET_OUT |=> !GROUP_CHANGE_RESET_OUT)
      else $error("change pulse longer than one cycle");
   pending_group_a: assert property (SWITCH_PENDING_OUT |-> GROUP_ONE_ACTIVE_OUT)
      else $error("pending while group two active");
   status_view_a: assert property (rd_taken_s(sgsel_pkg::OFS_STATUS) |=>
      HRDATA_OUT[2:0] == {SWITCH_PENDING_OUT, GROUP_TWO_ACTIVE_OUT, GROUP_ONE_ACTIVE_OUT})
      else $error("status read disagrees with outputs");
   hole_read_a: assert property (rd_taken_s(8'h10) |=> HRDATA_OUT == 32'h0)
      else $error("unmapped read not zero");
   reset_state_a: assert property (disable iff (1'b0) !RESETN_IN |=>
      GROUP_ONE_ACTIVE_OUT && !GROUP_CHANGE_RESET_OUT && !SWITCH_PENDING_OUT)
      else $error("reset state wrong");
endmodule

bind sgsel_top sgsel_assertions i_chk (.CORE_CLK_IN(CORE_CLK_IN), .RESETN_IN(RESETN_IN),
   .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN),
   .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT),
   .HRESP_OUT(HRESP_OUT), .GROUP_ONE_ACTIVE_OUT(GROUP_ONE_ACTIVE_OUT),
   .GROUP_TWO_ACTIVE_OUT(GROUP_TWO_ACTIVE_OUT),
   .GROUP_CHANGE_RESET_OUT(GROUP_CHANGE_RESET_OUT), .SWITCH_PENDING_OUT(SWITCH_PENDING_OUT));

// ===== testbench/sgsel_input_model.sv
`timescale 1ns/1ps
// ==========================================================
// binary input contact: level follows energization, one cycle late
module sgsel_input_model (
   input wire logic clk_in,
   input wire logic energized_in,
   output logic level_out
);
   // pure level, no pulse shaping: the selector must act on level alone
   always_ff @(posedge clk_in) begin
      level_out <= energized_in;
   end
endmodule

// ===== testbench/sgsel_top_tb_top.sv
`timescale 1ns/1ps
module sgsel_top_tb_top;
   localparam int TICK = 4;
   logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, energized = 1'b1, sel;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hready, hresp, g1, g2, chg, pend;
   int fail_count = 0, compares = 0, pulses = 0, n;
   sgsel_input_model i_inp (.clk_in(clk), .energized_in(energized), .level_out(sel));
   sgsel_top #(.TICK_CYCLES(TICK)) i_dut (.CORE_CLK_IN(clk), .RESETN_IN(rst_n), .HSEL_IN(hsel),
      .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize),
      .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
      .HRESP_OUT(hresp), .GROUP_SEL_IN(sel), .GROUP_ONE_ACTIVE_OUT(g1),
      .GROUP_TWO_ACTIVE_OUT(g2), .GROUP_CHANGE_RESET_OUT(chg), .SWITCH_PENDING_OUT(pend));
   initial begin
      forever #25 clk = ~clk;
   end
   // counted mid-cycle so a task woken at the edge reads a settled sum
   always @(negedge clk) begin
      if (chg === 1'b1) pulses <= pulses + 1;
   end
   // ==========================================================
   // helpers
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= {24'h0, a};
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   // waits for group two to equal v; n holds the cycles taken
   task automatic wait_grp(input logic v, input int lim);
      n = 0;
      while (g2 !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic drive(input logic e);
      energized <= e;
      @(posedge clk);
   endtask
   task automatic conclude;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_powerup;
      repeat (5) @(posedge clk);
      check({g2, pulses[0]}, 2'h2);
      rd_chk(sgsel_pkg::OFS_CTRL, 32'h0000000E);
      rd_chk(sgsel_pkg::OFS_DELAY, 32'h00000064);
      rd_chk(sgsel_pkg::OFS_REQUEST, 32'h00000001);
      rd_chk(8'h10, 32'h0);
      rd_chk(sgsel_pkg::OFS_STATUS, 32'h0000000A);
   endtask
   task automatic t_down_up;
      xfer(1'b1, sgsel_pkg::OFS_DELAY, 32'h3);
      drive(1'b0);
      wait_grp(1'b0, 20);
      check(n <= 5, 1);
      check(pulses, 1);
      drive(1'b1);
      repeat (8) @(posedge clk);
      check({pend, g1}, 2'h3);
      wait_grp(1'b1, 60);
      check(n >= 3 * TICK - 8 && n <= 3 * TICK + 4, 1);
      drive(1'b0);
      wait_grp(1'b0, 20);
      drive(1'b1);
      repeat (8) @(posedge clk);
      drive(1'b0);
      repeat (30) @(posedge clk);
      check({g2, pend}, 2'h0);
   endtask
   task automatic t_invert;
      xfer(1'b1, sgsel_pkg::OFS_CTRL, 32'h1E);
      wait_grp(1'b1, 60);
      check(n >= 3 * TICK - 4 && n <= 3 * TICK + 6, 1);
      drive(1'b1);
      wait_grp(1'b0, 20);
      check(g1, 1);
      xfer(1'b1, sgsel_pkg::OFS_CTRL, 32'h06);
      repeat (30) @(posedge clk);
      check(g1, 1);
      rd_chk(sgsel_pkg::OFS_STATUS, 32'h19);
      drive(1'b0);
   endtask
   task automatic t_request;
      xfer(1'b1, sgsel_pkg::OFS_CTRL, 32'h02);
      xfer(1'b1, sgsel_pkg::OFS_REQUEST, 32'h2);
      wait_grp(1'b1, 6);
      check(g2, 1);
      xfer(1'b1, sgsel_pkg::OFS_REQUEST, 32'h1);
      wait_grp(1'b0, 6);
      check(g1, 1);
      xfer(1'b1, sgsel_pkg::OFS_CTRL, 32'h0E);
      xfer(1'b1, sgsel_pkg::OFS_REQUEST, 32'h2);
      rd_chk(sgsel_pkg::OFS_REQUEST, 32'h1);
      xfer(1'b1, sgsel_pkg::OFS_CTRL, 32'h02);
      repeat (4) @(posedge clk);
      check(g1, 1);
      xfer(1'b1, sgsel_pkg::OFS_REQUEST, 32'h3);
      rd_chk(sgsel_pkg::OFS_REQUEST, 32'h1);
      xfer(1'b1, sgsel_pkg::OFS_REQUEST, 32'h2);
      wait_grp(1'b1, 6);
      check(g2, 1);
      xfer(1'b1, sgsel_pkg::OFS_CTRL, 32'h01);
      wait_grp(1'b0, 6);
      check(g1, 1);
      xfer(1'b1, sgsel_pkg::OFS_CTRL, 32'h03);
      rd_chk(sgsel_pkg::OFS_CTRL, 32'h01);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_powerup();
      t_down_up();
      t_invert();
      t_request();
      conclude();
   end
   initial begin
      #200us;
      fail_count++;
      conclude();
   end
endmodule
